//--- core/tss_pin_sync.sv
`timescale 1ns/1ps
module tss_pin_sync
    import tss_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Raw pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    // ==========================================================
    // Three-stage chain per bit, level moves when last two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic [SYNC_STAGES-1:0] stage_r;
            logic                   level_r;
            wire                    agree = (stage_r[1] == stage_r[2]);

            // Shift chain, first stage feeds only the second
            always_ff @(posedge core_clk_in) begin
                if (!rst_n_in) begin
                    stage_r <= '0;
                end else begin
                    stage_r <= {stage_r[1:0], pin_in[gi]};
                end
            end

            // Accepted level
            always_ff @(posedge core_clk_in) begin
                if (!rst_n_in) begin
                    level_r <= 1'b0;
                end else if (agree) begin
                    level_r <= stage_r[2];
                end
            end

            assign level_out[gi] = level_r;
        end
    endgenerate

endmodule

//--- core/tss_serial_config.sv
`timescale 1ns/1ps
module tss_serial_config
    import tss_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // Three-wire programming link
    input  wire logic                   sclk_in,
    input  wire logic                   sdata_in,
    input  wire logic                   sle_in,
    // Lock detectors and divider test taps
    input  wire logic                   lock_one_in,
    input  wire logic                   lock_two_in,
    input  wire logic                   ref_divider_out_one_in,
    input  wire logic                   prog_divider_out_one_in,
    input  wire logic                   ref_divider_out_two_in,
    input  wire logic                   prog_divider_out_two_in,
    // Open-collector shared pins, index is port number
    input  wire logic [PORT_BITS-1:0]   oc_port_in,
    output logic      [PORT_BITS-1:0]   oc_port_out,
    output logic      [PORT_BITS-1:0]   oc_port_oe_out,
    // Load pulse
    output logic                        load_pulse_out,
    // Synthesizer controls
    output logic      [1:0]             synth_power_up_out,
    output logic                        pump_high_current_out,
    output logic      [1:0]             pump_tristate_out,
    output logic      [1:0]             phase_polarity_out,
    // Division ratios
    output logic      [RF_TOT_BITS-1:0] total_rf_division_one_out,
    output logic      [RF_TOT_BITS-1:0] total_rf_division_two_out,
    output logic      [RD_TOT_BITS-1:0] total_reference_division_one_out,
    output logic      [RD_TOT_BITS-1:0] total_reference_division_two_out
);

    // ==========================================================
    // Input synchronisation
    localparam int SYNC_W = 9 + PORT_BITS;

    logic [SYNC_W-1:0] sync_level;

    tss_pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .pin_in      ({oc_port_in, prog_divider_out_two_in, ref_divider_out_two_in,
                       prog_divider_out_one_in, ref_divider_out_one_in,
                       lock_two_in, lock_one_in, sle_in, sdata_in, sclk_in}),
        .level_out   (sync_level)
    );

    // Named views of the filtered levels
    wire                 sclk_lvl  = sync_level[0];
    wire                 sdata_lvl = sync_level[1];
    wire                 sle_lvl   = sync_level[2];
    wire                 lock1_lvl = sync_level[3];
    wire                 lock2_lvl = sync_level[4];
    wire                 ref_divider_out_one_lvl  = sync_level[5];
    wire                 prog_divider_out_one_lvl  = sync_level[6];
    wire                 ref_divider_out_two_lvl  = sync_level[7];
    wire                 prog_divider_out_two_lvl  = sync_level[8];
    wire [PORT_BITS-1:0] port_lvl  = sync_level[SYNC_W-1:9];

    // ==========================================================
    // Edge detection on link signals
    logic sclk_prev_r;
    logic sle_prev_r;

    // Previous filtered levels
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            sclk_prev_r <= 1'b0;
            sle_prev_r  <= 1'b0;
        end else begin
            sclk_prev_r <= sclk_lvl;
            sle_prev_r  <= sle_lvl;
        end
    end

    wire sclk_rise = sclk_lvl & ~sclk_prev_r;
    wire sclk_fall = ~sclk_lvl & sclk_prev_r;
    wire sle_fall  = ~sle_lvl & sle_prev_r;

    // ==========================================================
    // Shift register
    logic [FRAME_BITS-1:0] shift_r;
    logic [FRAME_BITS-1:0] shift_nxt;
    wire                   shift_en = sle_lvl & sclk_rise;

    // MSB arrives first and walks up; old leading bits drop off the top
    assign shift_nxt = {shift_r[FRAME_BITS-2:0], sdata_lvl};

    // Capture on rising serial clock while enable high
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            shift_r <= '0;
        end else if (shift_en) begin
            shift_r <= shift_nxt;
        end
    end

    // ==========================================================
    // Frame decode
    wire [ADDR_BITS-1:0] frame_addr = shift_r[ADDR_LSB +: ADDR_BITS];
    wire [DATA_BITS-1:0] frame_data = shift_r[DATA_LSB +: DATA_BITS];

    // Address decode, taken at enable fall only; unused codes hit nothing
    wire wr_ms_one  = sle_fall & (frame_addr == ADDR_MS_ONE);
    wire wr_ref_one = sle_fall & (frame_addr == ADDR_REF_ONE);
    wire wr_ms_two  = sle_fall & (frame_addr == ADDR_MS_TWO);
    wire wr_ref_two = sle_fall & (frame_addr == ADDR_REF_TWO);
    wire wr_ctrl    = sle_fall & (frame_addr == ADDR_CTRL);
    wire wr_power   = sle_fall & (frame_addr == ADDR_POWER);

    // ==========================================================
    // Latches, kept regardless of power state
    tss_ms_t    ms_one_r;
    tss_ms_t    ms_two_r;
    logic [REF_BITS-1:0] ref_one_r;
    logic [REF_BITS-1:0] ref_two_r;
    tss_ctrl_t  ctrl_r;
    tss_power_t power_r;

    // Main and swallow latches
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ms_one_r <= tss_ms_t'(MS_RESET);
            ms_two_r <= tss_ms_t'(MS_RESET);
        end else begin
            if (wr_ms_one) begin
                ms_one_r <= tss_ms_t'(frame_data);
            end
            if (wr_ms_two) begin
                ms_two_r <= tss_ms_t'(frame_data);
            end
        end
    end

    // Reference latches
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ref_one_r <= REF_RESET;
            ref_two_r <= REF_RESET;
        end else begin
            if (wr_ref_one) begin
                ref_one_r <= frame_data[REF_BITS-1:0];
            end
            if (wr_ref_two) begin
                ref_two_r <= frame_data[REF_BITS-1:0];
            end
        end
    end

    // Control and power latches
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ctrl_r  <= tss_ctrl_t'(CTRL_RESET);
            power_r <= tss_power_t'(POWER_RESET);
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= tss_ctrl_t'(frame_data[CTRL_BITS-1:0]);
            end
            if (wr_power) begin
                power_r <= tss_power_t'(frame_data[PWR_BITS-1:0]);
            end
        end
    end

    // ==========================================================
    // Load pulse, from enable fall to next serial clock fall
    tss_load_state_t ld_state_r;
    tss_load_state_t ld_state_nxt;

    // Next state
    always_comb begin
        ld_state_nxt = ld_state_r;
        case (ld_state_r)
            LD_IDLE: begin
                if (sle_fall) begin
                    ld_state_nxt = LD_ACTIVE;
                end
            end
            LD_ACTIVE: begin
                if (sclk_fall) begin
                    ld_state_nxt = LD_IDLE;
                end
            end
            default: begin
                ld_state_nxt = LD_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            ld_state_r <= LD_IDLE;
        end else begin
            ld_state_r <= ld_state_nxt;
        end
    end

    // ==========================================================
    // Division ratios
    wire [RF_TOT_BITS-1:0] rf_tot_one_nxt =
        RF_TOT_BITS'({ms_one_r.main_count_bits, {PRESCALE_SHIFT{1'b0}}})
        + RF_TOT_BITS'(ms_one_r.swallow_count_bits);
    wire [RF_TOT_BITS-1:0] rf_tot_two_nxt =
        RF_TOT_BITS'({ms_two_r.main_count_bits, {PRESCALE_SHIFT{1'b0}}})
        + RF_TOT_BITS'(ms_two_r.swallow_count_bits);

    // All-zero reference count stands for the top of the range
    wire [12:0] ref_one_cnt = (ref_one_r == '0) ? REF_WRAP_VALUE : {1'b0, ref_one_r};
    wire [12:0] ref_two_cnt = (ref_two_r == '0) ? REF_WRAP_VALUE : {1'b0, ref_two_r};

    // Halving bit doubles both reference dividers
    wire [RD_TOT_BITS-1:0] rd_tot_one_nxt = ctrl_r.reference_halving_bit ?
        {ref_one_cnt, 1'b0} : {1'b0, ref_one_cnt};
    wire [RD_TOT_BITS-1:0] rd_tot_two_nxt = ctrl_r.reference_halving_bit ?
        {ref_two_cnt, 1'b0} : {1'b0, ref_two_cnt};

    // ==========================================================
    // Power control
    wire hpd1_lvl = port_lvl[1];
    wire hpd2_lvl = port_lvl[4];
    wire pwr_one_nxt = power_r.soft_power_one &
        (~ctrl_r.hw_power_select_one | hpd1_lvl);
    wire pwr_two_nxt = power_r.soft_power_two &
        (~ctrl_r.hw_power_select_two | hpd2_lvl);

    // Pump current for synthesizer one
    wire hi_cur_nxt = power_r.charge_current_switch &
        (~ctrl_r.current_input_select | port_lvl[0]);

    // ==========================================================
    // Lock pin function
    wire [1:0] lock_sel = {ctrl_r.lock_select_high, ctrl_r.lock_select_low};
    wire test_one = ctrl_r.counter_test & (lock_sel == LOCK_ONE);
    wire test_two = ctrl_r.counter_test & (lock_sel == LOCK_TWO);

    // Test taps chosen by phase bit
    wire test_sig_one = ctrl_r.phase_polarity_one ? ref_divider_out_one_lvl : prog_divider_out_one_lvl;
    wire test_sig_two = ctrl_r.phase_polarity_two ? ref_divider_out_two_lvl : prog_divider_out_two_lvl;

    // Level wanted on the lock pin, open-collector so low means drive
    logic lock_pin_level;
    always_comb begin
        if (test_one) begin
            lock_pin_level = test_sig_one;
        end else if (test_two) begin
            lock_pin_level = test_sig_two;
        end else begin
            case (lock_sel)
                LOCK_PORT:  lock_pin_level = ctrl_r.open_collector_port_bits[2];
                LOCK_TWO:   lock_pin_level = lock2_lvl;
                LOCK_ONE:   lock_pin_level = lock1_lvl;
                LOCK_WIRED: lock_pin_level = lock1_lvl | lock2_lvl;
                default:    lock_pin_level = 1'b1;
            endcase
        end
    end

    // ==========================================================
    // Open-collector drive, pins used as inputs never pulled
    logic [PORT_BITS-1:0] port_drive_nxt;
    wire  [PORT_BITS-1:0] port_bits = ctrl_r.open_collector_port_bits;
    assign port_drive_nxt[0] = ~ctrl_r.current_input_select & ~port_bits[0];
    assign port_drive_nxt[1] = ~ctrl_r.hw_power_select_one & ~port_bits[1];
    assign port_drive_nxt[2] = ~lock_pin_level;
    assign port_drive_nxt[3] = ~port_bits[3];
    assign port_drive_nxt[4] = ~ctrl_r.hw_power_select_two & ~port_bits[4];

    // ==========================================================
    // Output registers
    logic [PORT_BITS-1:0]   port_oe_r;
    logic                   load_r;
    logic [1:0]             pwr_r;
    logic                   hi_cur_r;
    logic [1:0]             tri_r;
    logic [1:0]             pol_r;
    logic [RF_TOT_BITS-1:0] rf_tot_one_r;
    logic [RF_TOT_BITS-1:0] rf_tot_two_r;
    logic [RD_TOT_BITS-1:0] rd_tot_one_r;
    logic [RD_TOT_BITS-1:0] rd_tot_two_r;

    // Pin and control outputs
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            port_oe_r <= '0;
            load_r    <= 1'b0;
            pwr_r     <= 2'h0;
            hi_cur_r  <= 1'b0;
            tri_r     <= 2'h0;
            pol_r     <= 2'h0;
        end else begin
            port_oe_r <= port_drive_nxt;
            load_r    <= (ld_state_nxt == LD_ACTIVE);
            pwr_r     <= {pwr_two_nxt, pwr_one_nxt};
            hi_cur_r  <= hi_cur_nxt;
            tri_r     <= {ctrl_r.pump_tristate_two, ctrl_r.pump_tristate_one};
            pol_r     <= {ctrl_r.phase_polarity_two, ctrl_r.phase_polarity_one};
        end
    end

    // Ratio outputs
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            rf_tot_one_r <= '0;
            rf_tot_two_r <= '0;
            rd_tot_one_r <= '0;
            rd_tot_two_r <= '0;
        end else begin
            rf_tot_one_r <= rf_tot_one_nxt;
            rf_tot_two_r <= rf_tot_two_nxt;
            rd_tot_one_r <= rd_tot_one_nxt;
            rd_tot_two_r <= rd_tot_two_nxt;
        end
    end

    // Drive low only ever; released pins float high externally
    logic [PORT_BITS-1:0] port_low_r;
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            port_low_r <= '0;
        end else begin
            port_low_r <= '0;
        end
    end

    // ==========================================================
    // Port connections
    assign oc_port_out                      = port_low_r;
    assign oc_port_oe_out                   = port_oe_r;
    assign load_pulse_out                   = load_r;
    assign synth_power_up_out               = pwr_r;
    assign pump_high_current_out            = hi_cur_r;
    assign pump_tristate_out                = tri_r;
    assign phase_polarity_out               = pol_r;
    assign total_rf_division_one_out        = rf_tot_one_r;
    assign total_rf_division_two_out        = rf_tot_two_r;
    assign total_reference_division_one_out = rd_tot_one_r;
    assign total_reference_division_two_out = rd_tot_two_r;

endmodule

//--- include/tss_pkg.sv
// Contract
// - While enable high, data bits shift in on serial clock rise, MSB first.
// - Enable falling copies shifted data into latch chosen by last three bits.
// - Clock pulses are not counted; excess leading bits simply fall out.
// - Serial link keeps accepting and latching frames while synthesizers are powered down.
// - Address decoded at enable fall; load pulse lasts until next clock fall.
// - Six addresses: 001,010,011,100,101,110 select the six latches.
// - Frame is 20 bits: D16..D0 then address A2..A0.
// - Swallow count is D5..D0, 0 to 63, below main count.
// - Main count is D16..D6, range 5 to 2047.
// - RF division equals sixty-four times main count plus swallow count.
// - Reference count is D11..D0 of reference latch, range 5 to 4096.
// - Reference halving bit set doubles the total reference division.
// - Open-collector port bit 0 pulls pin low, 1 releases it.
// - Lock select: 00 port two, 01 lock two, 10 lock one, 11 both ORed.
// - Hardware power select 0 makes pin a port, 1 a power-down input.
// - Current input select 0 makes pin port zero, 1 current switch input.
// - Phase bit 1 normal pump polarity, 0 inverted.
// - Soft power bit 0 powers down, 1 up, when hardware select is 0.
// - Hardware mode needs select and soft bit high; pin level sets power.
// - High pump current needs switch bit and, if selected, high current pin.
// - Tristate bit 1 puts charge pump output in high impedance.
// - Counter test drives divider signals onto lock pin per select and phase.
package tss_pkg;

    // ==========================================================
    // Frame layout
    localparam int FRAME_BITS  = 20;
    localparam int DATA_BITS   = 17;
    localparam int ADDR_BITS   = 3;
    localparam int ADDR_LSB    = 0;
    localparam int DATA_LSB    = 3;
    localparam int MAIN_BITS   = 11;
    localparam int SWAL_BITS   = 6;
    localparam int REF_BITS    = 12;
    localparam int CTRL_BITS   = 16;
    localparam int PWR_BITS    = 3;
    localparam int PORT_BITS   = 5;
    localparam int RF_TOT_BITS = 17;
    localparam int RD_TOT_BITS = 14;
    localparam int SYNC_STAGES = 3;

    // ==========================================================
    // Latch addresses
    localparam logic [2:0] ADDR_MS_ONE  = 3'h1;
    localparam logic [2:0] ADDR_REF_ONE = 3'h2;
    localparam logic [2:0] ADDR_MS_TWO  = 3'h3;
    localparam logic [2:0] ADDR_REF_TWO = 3'h4;
    localparam logic [2:0] ADDR_CTRL    = 3'h5;
    localparam logic [2:0] ADDR_POWER   = 3'h6;

    // ==========================================================
    // Divider arithmetic
    localparam int               PRESCALE_SHIFT = 6;
    localparam logic [12:0]      REF_WRAP_VALUE = 13'h1000;

    // ==========================================================
    // Values after reset
    localparam logic [16:0] MS_RESET    = 17'h00000;
    localparam logic [11:0] REF_RESET   = 12'h000;
    localparam logic [15:0] CTRL_RESET  = 16'h001F;
    localparam logic [2:0]  POWER_RESET = 3'h0;

    // ==========================================================
    // Lock pin functions
    localparam logic [1:0] LOCK_PORT  = 2'h0;
    localparam logic [1:0] LOCK_TWO   = 2'h1;
    localparam logic [1:0] LOCK_ONE   = 2'h2;
    localparam logic [1:0] LOCK_WIRED = 2'h3;

    // ==========================================================
    // Latch contents
    typedef struct packed {
        logic [10:0] main_count_bits;
        logic [5:0]  swallow_count_bits;
    } tss_ms_t;

    typedef struct packed {
        logic       reference_halving_bit;
        logic       counter_test;
        logic       current_input_select;
        logic       pump_tristate_two;
        logic       pump_tristate_one;
        logic       phase_polarity_two;
        logic       phase_polarity_one;
        logic       hw_power_select_two;
        logic       hw_power_select_one;
        logic       lock_select_low;
        logic       lock_select_high;
        logic [4:0] open_collector_port_bits;
    } tss_ctrl_t;

    typedef struct packed {
        logic charge_current_switch;
        logic soft_power_two;
        logic soft_power_one;
    } tss_power_t;

    // Load pulse state
    typedef enum logic [0:0] {
        LD_IDLE   = 1'b0,
        LD_ACTIVE = 1'b1
    } tss_load_state_t;

endpackage

//--- sim/tss_link_ctl.sv
`timescale 1ns/1ps
// ==========================================================
// Controller model for the three-wire link
module tss_link_ctl (
    // Clock
    input  wire logic core_clk_in,
    // Link pins
    output logic      sclk_out,
    output logic      sdata_out,
    output logic      sle_out
);
    // Link idle at start
    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
        sle_out = 1'b0;
    end
    // One link clock phase, four core cycles
    task automatic ph();
        repeat (4) @(negedge core_clk_in);
    endtask
    // Shifts the low n bits of f, top bit first
    task automatic frame(input logic [23:0] f, input int n);
        sle_out = 1'b1;
        ph();
        for (int i = n - 1; i >= 0; i--) begin
            sdata_out = f[i];
            ph();
            sclk_out = 1'b1;
            ph();
            sclk_out = 1'b0;
        end
        ph();
        sle_out = 1'b0;
        sdata_out = ~sdata_out; // Stale bit no longer held
        ph();
        sclk_out = 1'b1;
        ph();
        sclk_out = 1'b0;
        repeat (3) ph();
    endtask
endmodule

//--- sim/tss_serial_config_chk.sv
`timescale 1ns/1ps
// ==========================================================
// Port checker for the serial configuration block
module tss_serial_config_chk
    import tss_pkg::*;
(
    // Clock and reset
    input wire logic                   core_clk_in,
    input wire logic                   rst_n_in,
    // Link pins
    input wire logic                   sclk_in,
    input wire logic                   sle_in,
    // Observed outputs
    input wire logic [PORT_BITS-1:0]   oc_port_out,
    input wire logic                   load_pulse_out,
    input wire logic                   pump_high_current_out,
    input wire logic [1:0]             pump_tristate_out,
    input wire logic [1:0]             phase_polarity_out,
    input wire logic [RF_TOT_BITS-1:0] total_rf_division_one_out,
    input wire logic [RF_TOT_BITS-1:0] total_rf_division_two_out,
    input wire logic [RD_TOT_BITS-1:0] total_reference_division_one_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Load pulse bounded by enable fall and clock fall
    load_rise_a: assert property ($rose(load_pulse_out) |-> !$past(sle_in, 3) && $past(sle_in, 7))
        else $error("load pulse without enable fall");
    load_fall_a: assert property ($fell(load_pulse_out) |-> !$past(sclk_in, 3))
        else $error("load pulse ended without clock fall");
    // Results move only on a load; the reference total may also move just after reset
    rf_one_hold_a: assert property ($changed(total_rf_division_one_out) |-> $past(load_pulse_out))
        else $error("rf total one moved without load");
    rf_two_hold_a: assert property ($changed(total_rf_division_two_out) |-> $past(load_pulse_out))
        else $error("rf total two moved without load");
    ref_hold_a: assert property ($changed(total_reference_division_one_out) |->
        $past(load_pulse_out) || !$past(rst_n_in) || !$past(rst_n_in, 2))
        else $error("reference total moved without load");
    tri_hold_a: assert property ($changed(pump_tristate_out) |-> $past(load_pulse_out))
        else $error("tristate moved without load");
    phase_hold_a: assert property ($changed(phase_polarity_out) |-> $past(load_pulse_out))
        else $error("polarity moved without load");
    // Open-collector pins only ever pull low
    port_low_a: assert property (oc_port_out == '0)
        else $error("port driven high");
    // Main scenarios
    cover property ($rose(load_pulse_out));
    cover property ($changed(total_rf_division_two_out));
    cover property ($fell(pump_high_current_out));
endmodule

bind tss_serial_config tss_serial_config_chk chk (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk_in), .sle_in(sle_in),
    .oc_port_out(oc_port_out), .load_pulse_out(load_pulse_out), .pump_high_current_out(pump_high_current_out),
    .pump_tristate_out(pump_tristate_out), .phase_polarity_out(phase_polarity_out),
    .total_rf_division_one_out(total_rf_division_one_out), .total_rf_division_two_out(total_rf_division_two_out),
    .total_reference_division_one_out(total_reference_division_one_out));

//--- sim/tss_serial_config_test.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the serial configuration block
module tss_serial_config_test;
    import tss_pkg::*;
    // Frame to send, then result to look at
    typedef struct packed {
        logic        go;
        logic [2:0]  a;
        logic [16:0] d;
        logic [3:0]  k;
        logic [16:0] e;
    } tss_row_t;
    logic                   core_clk_in, rst_n_in, sclk, sdata, sle, lock_one, lock_two, load, hc, tap;
    logic [PORT_BITS-1:0]   ext_lvl, oc_port_in, oc_port_out, oe;
    logic [1:0]             pwr, tri_s, ph;
    logic [RF_TOT_BITS-1:0] rf1, rf2;
    logic [RD_TOT_BITS-1:0] rd1, rd2;
    int                     n_mismatch = 0, n_tests = 0, cyc = 0;
    tss_row_t               rows [13] = '{
        '{1'b1, ADDR_MS_ONE, {11'h064, 6'h07}, 4'h0, 17'h01907},
        '{1'b1, ADDR_MS_TWO, {11'h7FF, 6'h3F}, 4'h1, 17'h1FFFF},
        '{1'b1, ADDR_REF_ONE, 17'h00005, 4'h2, 17'h00005},
        '{1'b1, ADDR_REF_TWO, 17'h00000, 4'h3, 17'h01000},
        '{1'b1, ADDR_POWER, 17'h00007, 4'h4, 17'h00003},
        '{1'b0, 3'h0, 17'h00000, 4'h5, 17'h00001},
        '{1'b1, ADDR_CTRL, 17'h0B216, 4'h2, 17'h0000A},
        '{1'b0, 3'h0, 17'h00000, 4'h3, 17'h02000},
        '{1'b0, 3'h0, 17'h00000, 4'h6, 17'h00002},
        '{1'b0, 3'h0, 17'h00000, 4'h7, 17'h00001},
        '{1'b0, 3'h0, 17'h00000, 4'h8, 17'h00008},
        '{1'b1, 3'h0, 17'h1FFFF, 4'h0, 17'h01907},
        '{1'b1, 3'h7, 17'h1FFFF, 4'h8, 17'h00008}};
    // Shared pins: low while pulled, else outside level
    assign oc_port_in = ~oe & ext_lvl;
    tss_serial_config DUT (
        .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .sdata_in(sdata), .sle_in(sle),
        .lock_one_in(lock_one), .lock_two_in(lock_two), .ref_divider_out_one_in(tap),
        .prog_divider_out_one_in(1'b0), .ref_divider_out_two_in(1'b0), .prog_divider_out_two_in(1'b0),
        .oc_port_in(oc_port_in), .oc_port_out(oc_port_out), .oc_port_oe_out(oe), .load_pulse_out(load),
        .synth_power_up_out(pwr), .pump_high_current_out(hc), .pump_tristate_out(tri_s),
        .phase_polarity_out(ph), .total_rf_division_one_out(rf1), .total_rf_division_two_out(rf2),
        .total_reference_division_one_out(rd1), .total_reference_division_two_out(rd2));
    tss_link_ctl ctl (.core_clk_in(core_clk_in), .sclk_out(sclk), .sdata_out(sdata), .sle_out(sle));
    // Picks one result, widened
    function automatic logic [16:0] get(input logic [3:0] k);
        case (k)
            4'h0: get = rf1;
            4'h1: get = rf2;
            4'h2: get = 17'(rd1);
            4'h3: get = 17'(rd2);
            4'h4: get = 17'(pwr);
            4'h5: get = 17'(hc);
            4'h6: get = 17'(tri_s);
            4'h7: get = 17'(ph);
            default: get = 17'(oe);
        endcase
    endfunction
    // Compare and count
    task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Clock
    initial begin
        core_clk_in = 1'b0;
        forever #12.5 core_clk_in = ~core_clk_in;
    end
    // Hang guard
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        ext_lvl = 5'h1F;
        lock_one = 1'b0;
        lock_two = 1'b1;
        tap = 1'b0;
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge core_clk_in);
        foreach (rows[i]) begin
            if (rows[i].go)
                ctl.frame({4'h0, rows[i].d, rows[i].a}, 20);
            chk($sformatf("row%0d", i), rows[i].e, get(rows[i].k));
        end
        $display("table done");
        ctl.frame({4'hA, 11'h005, 6'h04, ADDR_MS_ONE}, 24);
        chk("extra bits", 17'h00144, rf1);
        $display("extra bits done");
        ext_lvl[0] = 1'b0;
        repeat (8) @(negedge core_clk_in);
        chk("pump current", 17'h00000, 17'(hc));
        $display("current pin done");
        ext_lvl[1] = 1'b0;
        for (int c = 0; c < 4; c++) begin
            ctl.frame({4'h0, 1'b0, 16'hB296 | {9'h000, c[0], c[1], 5'h00}, ADDR_CTRL}, 20);
            chk("lock pin", (c == 2) ? 17'h0000C : 17'h00008, 17'(oe));
        end
        chk("hw power", 17'h00002, 17'(pwr));
        ctl.frame({4'h0, 17'h0423F, ADDR_CTRL}, 20);
        chk("test tap low", 17'h00001, 17'(oe[2]));
        tap = 1'b1;
        repeat (8) @(negedge core_clk_in);
        chk("test tap high", 17'h00000, 17'(oe[2]));
        $display("lock and power done");
        rst_n_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        repeat (3) @(negedge core_clk_in);
        chk("reset rf", 17'h00000, rf1);
        chk("reset ref", 17'h01000, 17'(rd1));
        chk("reset oe", 17'h00000, 17'(oe));
        chk("reset power", 17'h00000, 17'(pwr));
        $display("reset done");
        wrap_up();
    end
endmodule
